/* File: src/iep_regs.vh */
// Constants for the interrupt enable and level block: offsets, fields, resets.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register per word.
//
// How it works
// - Bit 7 of the main enable register lets interrupts through when 1 and blocks all when 0.
// - Main enable bits 6, 5 and 4 enable the second serial port, watchdog and first serial port.
// - Main enable bits 3, 2, 1 and 0 enable timer 1, external 1, timer 0 and external 0.
// - Bit 7 of the second enable register enables the shared group of external lines 8 to 15.
// - Bit 6 of the second enable register enables the shared group of external lines 2 to 7.
// - Second enable bits 5, 4, 2, 1 and 0 enable converter, timer 5, timer 4, timer 3 and SPI.
// - A 2-bit level field codes level 0 (lowest) to level 3 (highest) as its binary value.
// - Level bank A holds timer 1, external 1, timer 0 and external 0 from top pair to bottom.
// - Level bank B holds serial 2, low voltage, watchdog and serial 1 from top pair to bottom.
// - Level bank C holds modulator, timer 4, timer 3 and SPI from top pair to bottom.
// - Level bank D holds line group 8-15, line group 2-7, converter and timer 5.
// - A request is offered only when its flag, its enable and the global enable are all set.
// - A running handler is preempted only by a strictly higher level; level 3 is never preempted.
// - Equal levels arriving together are served in fixed polling order, external 0 first.
// - Only the return from handler clears the in-service level; a plain return leaves it set.
`ifndef IEP_REGS_VH
`define IEP_REGS_VH

`define IEP_OFS_MAIN_EN      8'h00
`define IEP_OFS_SECOND_EN    8'h04
`define IEP_OFS_LEVEL_A      8'h08
`define IEP_OFS_LEVEL_B      8'h0c
`define IEP_OFS_LEVEL_C      8'h10
`define IEP_OFS_LEVEL_D      8'h14
`define IEP_OFS_STATUS       8'h18

`define IEP_RST_REG          8'h00
`define IEP_SECOND_EN_WMASK  8'hf7

`define IEP_BIT_GLOBAL_EN    7
`define IEP_BIT_SERIAL2_EN   6
`define IEP_BIT_WATCHDOG_EN  5
`define IEP_BIT_SERIAL1_EN   4
`define IEP_BIT_TIMER1_EN    3
`define IEP_BIT_EXT1_EN      2
`define IEP_BIT_TIMER0_EN    1
`define IEP_BIT_EXT0_EN      0
`define IEP_BIT_GRP_HI_EN    7
`define IEP_BIT_GRP_LO_EN    6
`define IEP_BIT_CONV_EN      5
`define IEP_BIT_TIMER5_EN    4
`define IEP_BIT_TIMER4_EN    2
`define IEP_BIT_TIMER3_EN    1
`define IEP_BIT_SPI_EN       0

`define IEP_NUM_SRC          16
`define IEP_TOP_LEVEL        2'h3

`endif

/* File: src/iep_arbiter.v */
// Picks the winning request: highest level, then lowest polling index.
// Assumes requests already gated by their enables; purely combinational.
`include "iep_regs.vh"

module iep_arbiter #(
    parameter NUM_SRC = `IEP_NUM_SRC
) (
    req,
    levels,
    win_any,
    win_index,
    win_level
);
    input  wire [NUM_SRC-1:0]   req;
    input  wire [2*NUM_SRC-1:0] levels;
    output reg                  win_any;
    output reg  [3:0]           win_index;
    output reg  [1:0]           win_level;

    integer i;

    // Descending scan with >= lets the lower index win a tie
    always @* begin
        win_any   = 1'b0;
        win_index = 4'h0;
        win_level = 2'h0;
        for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (req[i] && (!win_any || levels[2*i +: 2] >= win_level)) begin
                win_any   = 1'b1;
                win_index = i[3:0];
                win_level = levels[2*i +: 2];
            end
        end
    end
endmodule // iep_arbiter

/* File: src/iep_top.v */
// Interrupt enable, level registers, arbitration and in-service tracking.
// Assumes request flags come from logic on clk; the core pulses arb_point
// at instruction boundaries, irq_take on vector fetch, return_from_handler on return.
//
// Chosen here: register access over Avalon-MM and the address map.
`include "iep_regs.vh"

module iep_top #(
    parameter NUM_SRC = `IEP_NUM_SRC
) (
    clk,
    arst_n,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_byteenable,
    avs_readdata,
    avs_waitrequest,
    req_flags,
    lvd_irq_enable,
    pwm_irq_enable,
    arb_point,
    irq_take,
    return_from_handler,
    irq_pending,
    irq_index,
    irq_level,
    in_service
);
    input  wire                clk;
    input  wire                arst_n;
    input  wire [7:0]          avs_address;
    input  wire                avs_read;
    input  wire                avs_write;
    input  wire [31:0]         avs_writedata;
    input  wire [3:0]          avs_byteenable;
    output wire [31:0]         avs_readdata;
    output wire                avs_waitrequest;
    input  wire [NUM_SRC-1:0]  req_flags;
    input  wire                lvd_irq_enable;
    input  wire                pwm_irq_enable;
    input  wire                arb_point;
    input  wire                irq_take;
    input  wire                return_from_handler;
    output wire                irq_pending;
    output wire [3:0]          irq_index;
    output wire [1:0]          irq_level;
    output wire [3:0]          in_service;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [7:0]         main_irq_enable_ff;
    reg  [7:0]         second_irq_enable_ff;
    reg  [7:0]         irq_level_bank_a_ff;
    reg  [7:0]         irq_level_bank_b_ff;
    reg  [7:0]         irq_level_bank_c_ff;
    reg  [7:0]         irq_level_bank_d_ff;
    reg                ack_ff;
    reg  [31:0]        rdata_ff;
    reg                pending_ff;
    reg  [3:0]         index_ff;
    reg  [1:0]         level_ff;
    reg  [3:0]         in_service_ff;

    reg  [31:0]        nxt_rdata;
    reg  [3:0]         nxt_in_service;

    wire               bus_req;
    wire               wr_ok;
    wire [NUM_SRC-1:0] src_enable;
    wire [NUM_SRC-1:0] gated_req;
    wire [2*NUM_SRC-1:0] levels;
    wire               win_any;
    wire [3:0]         win_index;
    wire [1:0]         win_level;
    wire               busy;
    wire [1:0]         busy_level;
    wire               may_preempt;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function [1:0] top_level;
        input [3:0] bits;
        begin
            if (bits[3]) begin
                top_level = 2'h3;
            end else if (bits[2]) begin
                top_level = 2'h2;
            end else if (bits[1]) begin
                top_level = 2'h1;
            end else begin
                top_level = 2'h0;
            end
        end
    endfunction

    function [3:0] level_bit;
        input [1:0] lvl;
        begin
            level_bit = 4'h1 << lvl;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave, one wait state per access

    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_ff;
    assign avs_readdata    = rdata_ff;
    assign wr_ok           = avs_write & ack_ff & avs_byteenable[0];

    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (avs_address == `IEP_OFS_MAIN_EN) begin
            nxt_rdata[7:0] = main_irq_enable_ff;
        end else if (avs_address == `IEP_OFS_SECOND_EN) begin
            nxt_rdata[7:0] = second_irq_enable_ff;
        end else if (avs_address == `IEP_OFS_LEVEL_A) begin
            nxt_rdata[7:0] = irq_level_bank_a_ff;
        end else if (avs_address == `IEP_OFS_LEVEL_B) begin
            nxt_rdata[7:0] = irq_level_bank_b_ff;
        end else if (avs_address == `IEP_OFS_LEVEL_C) begin
            nxt_rdata[7:0] = irq_level_bank_c_ff;
        end else if (avs_address == `IEP_OFS_LEVEL_D) begin
            nxt_rdata[7:0] = irq_level_bank_d_ff;
        end else if (avs_address == `IEP_OFS_STATUS) begin
            nxt_rdata[11:0] = {in_service_ff, level_ff, index_ff, 1'b0, pending_ff};
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
            if (avs_read & ~ack_ff) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            main_irq_enable_ff   <= `IEP_RST_REG;
            second_irq_enable_ff <= `IEP_RST_REG;
            irq_level_bank_a_ff  <= `IEP_RST_REG;
            irq_level_bank_b_ff  <= `IEP_RST_REG;
            irq_level_bank_c_ff  <= `IEP_RST_REG;
            irq_level_bank_d_ff  <= `IEP_RST_REG;
        end else if (wr_ok) begin
            if (avs_address == `IEP_OFS_MAIN_EN) begin
                main_irq_enable_ff <= avs_writedata[7:0];
            end else if (avs_address == `IEP_OFS_SECOND_EN) begin
                // Reserved bit stays zero
                second_irq_enable_ff <= avs_writedata[7:0] & `IEP_SECOND_EN_WMASK;
            end else if (avs_address == `IEP_OFS_LEVEL_A) begin
                irq_level_bank_a_ff <= avs_writedata[7:0];
            end else if (avs_address == `IEP_OFS_LEVEL_B) begin
                irq_level_bank_b_ff <= avs_writedata[7:0];
            end else if (avs_address == `IEP_OFS_LEVEL_C) begin
                irq_level_bank_c_ff <= avs_writedata[7:0];
            end else if (avs_address == `IEP_OFS_LEVEL_D) begin
                irq_level_bank_d_ff <= avs_writedata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source enables and levels in polling order

    assign src_enable[0]  = main_irq_enable_ff[`IEP_BIT_EXT0_EN];
    assign src_enable[1]  = main_irq_enable_ff[`IEP_BIT_TIMER0_EN];
    assign src_enable[2]  = main_irq_enable_ff[`IEP_BIT_EXT1_EN];
    assign src_enable[3]  = main_irq_enable_ff[`IEP_BIT_TIMER1_EN];
    assign src_enable[4]  = main_irq_enable_ff[`IEP_BIT_SERIAL1_EN];
    assign src_enable[5]  = main_irq_enable_ff[`IEP_BIT_WATCHDOG_EN];
    // Low-voltage and modulator enables live in their own peripherals
    assign src_enable[6]  = lvd_irq_enable;
    assign src_enable[7]  = main_irq_enable_ff[`IEP_BIT_SERIAL2_EN];
    assign src_enable[8]  = second_irq_enable_ff[`IEP_BIT_SPI_EN];
    assign src_enable[9]  = second_irq_enable_ff[`IEP_BIT_TIMER3_EN];
    assign src_enable[10] = second_irq_enable_ff[`IEP_BIT_TIMER4_EN];
    assign src_enable[11] = pwm_irq_enable;
    assign src_enable[12] = second_irq_enable_ff[`IEP_BIT_TIMER5_EN];
    assign src_enable[13] = second_irq_enable_ff[`IEP_BIT_CONV_EN];
    assign src_enable[14] = second_irq_enable_ff[`IEP_BIT_GRP_LO_EN];
    assign src_enable[15] = second_irq_enable_ff[`IEP_BIT_GRP_HI_EN];

    // Global gate over every flag and enable pair
    assign gated_req = req_flags & src_enable
                     & {NUM_SRC{main_irq_enable_ff[`IEP_BIT_GLOBAL_EN]}};

    // Bank order matches polling order two bits per source
    assign levels = {irq_level_bank_d_ff, irq_level_bank_c_ff,
                     irq_level_bank_b_ff, irq_level_bank_a_ff};

    iep_arbiter #(
        .NUM_SRC   (NUM_SRC)
    ) u_arbiter (
        .req       (gated_req),
        .levels    (levels),
        .win_any   (win_any),
        .win_index (win_index),
        .win_level (win_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration and in-service levels

    assign busy        = |in_service_ff;
    assign busy_level  = top_level(in_service_ff);
    assign may_preempt = !busy || (busy_level != `IEP_TOP_LEVEL && win_level > busy_level);

    // Offer is sampled only at arbitration points so a register write
    // never retargets a vector the core is already fetching
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_ff <= 1'b0;
            index_ff   <= 4'h0;
            level_ff   <= 2'h0;
        end else if (irq_take) begin
            pending_ff <= 1'b0;
        end else if (arb_point) begin
            pending_ff <= win_any & may_preempt;
            index_ff   <= win_index;
            level_ff   <= win_level;
        end
    end

    // Return clears the top level first, then a same-cycle take sets its own
    always @* begin
        nxt_in_service = in_service_ff;
        if (return_from_handler && busy) begin
            nxt_in_service = in_service_ff & ~level_bit(busy_level);
        end
        if (irq_take && pending_ff) begin
            nxt_in_service = nxt_in_service | level_bit(level_ff);
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            in_service_ff <= 4'h0;
        end else begin
            in_service_ff <= nxt_in_service;
        end
    end

    assign irq_pending = pending_ff;
    assign irq_index   = index_ff;
    assign irq_level   = level_ff;
    assign in_service  = in_service_ff;
endmodule // iep_top

/* File: tb/iep_chk.sv */
// Port assertions for the enable and level block.
// Bound into every iep_top; one clock domain.
module iep_chk (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        arb_point,
    input wire logic        irq_take,
    input wire logic        return_from_handler,
    input wire logic        irq_pending,
    input wire logic [3:0]  irq_index,
    input wire logic [1:0]  irq_level,
    input wire logic [3:0]  in_service
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire       rd_done = avs_read && !avs_waitrequest;
    wire       ret     = return_from_handler;
    wire       arb     = arb_point && !irq_take && !ret;
    wire       tk      = irq_take && irq_pending;
    wire       quiet   = !arb_point && !irq_take;
    wire [1:0] top     = in_service[3] ? 2'h3 : in_service[2] ? 2'h2 : {1'b0, in_service[1]};
    // Top level removed, as a return should leave it
    wire [3:0] drop    = in_service & ~(4'h1 << top);
    ////////////////////////////////////////
    chk_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered after one wait");
    chk_rsvd_zero: assert property (rd_done && avs_address == 8'h04 |=> !avs_readdata[3])
        else $error("reserved enable bit reads one");
    chk_take_drop: assert property (tk |=> !irq_pending)
        else $error("offer kept after take");
    chk_take_mark: assert property (tk |=> in_service[$past(irq_level)])
        else $error("taken level not marked");
    chk_top_block: assert property (arb && in_service[3] |=> !irq_pending)
        else $error("offer above top level");
    chk_only_above: assert property (arb && in_service != 4'h0
        |=> !irq_pending || irq_level > $past(top))
        else $error("offer not above level in service");
    chk_hold_offer: assert property (quiet |=> $stable({irq_pending, irq_index, irq_level}))
        else $error("offer changed between boundaries");
    chk_ret_only: assert property (!ret |=> ($past(in_service) & ~in_service) == 4'h0)
        else $error("level cleared without return");
    chk_ret_top: assert property (ret && !irq_take |=> in_service == $past(drop))
        else $error("return did not clear top level");
endmodule // iep_chk

bind iep_top iep_chk u_chk (.*);

/* File: tb/iep_core_model.sv */
// Core-side model: instruction boundaries, vector fetch, handler return.
// Each strobe lasts one cycle and starts right after a rising edge.
module iep_core_model (
    input  wire logic clk,
    output logic      arb_point,
    output logic      irq_take,
    output logic      return_from_handler
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        arb_point = 1'b0;
        irq_take = 1'b0;
        return_from_handler = 1'b0;
    end
    // Kind 0 boundary, 1 fetch, 2 return; dly models a slow core
    task automatic strobe(input int kind, input int dly);
        repeat (dly + 1) @(posedge clk);
        arb_point <= (kind == 0);
        irq_take <= (kind == 1);
        return_from_handler <= (kind == 2);
        @(posedge clk);
        {arb_point, irq_take, return_from_handler} <= 3'h0;
        @(posedge clk);
    endtask
endmodule // iep_core_model

/* File: tb/tb.sv */
// Self-checking bench for iep_top: register table, enables, levels, nesting.
// Assumes the core model drives the boundary, fetch and return strobes.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, arst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0]  avs_byteenable = 4'h1;
    logic        avs_waitrequest, arb_point, irq_take, return_from_handler, irq_pending;
    logic [15:0] req_flags = 16'h0;
    logic        lvd_irq_enable = 1'b0, pwm_irq_enable = 1'b0;
    logic [3:0]  irq_index, in_service;
    logic [1:0]  irq_level;
    int          err_total = 0, check_count = 0;
    logic [7:0]  row_a[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
    logic [7:0]  row_w[7] = '{8'hff, 8'hff, 8'ha5, 8'h5a, 8'hc3, 8'h3c, 8'hff};
    logic [7:0]  row_e[7] = '{8'hff, 8'hf7, 8'ha5, 8'h5a, 8'hc3, 8'h3c, 8'h00};
    // Enable place per source: 0b main bit b, 1b second bit b, 20 port
    logic [7:0]  en_map[16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h20, 8'h06,
                                8'h10, 8'h11, 8'h12, 8'h20, 8'h14, 8'h15, 8'h16, 8'h17};
    iep_top u_iep_top (.*);
    iep_core_model u_core (.*);
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("counts: %0d checks, %0d errors", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            $display("[ERR] t=%0t bus timeout %h", $time, a);
            close_out();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask
    // Banks A..D from low byte to high byte
    task automatic lvls(input logic [31:0] v);
        for (int k = 0; k < 4; k++) bus(1'b1, 8'h08 + 8'(4 * k), v[8*k+:8]);
    endtask
    task automatic offer(input logic p, input logic [3:0] i, input logic [1:0] l);
        u_core.strobe(0, 0);
        if (p) chk({irq_pending, irq_index, irq_level}, {p, i, l});
        else chk(irq_pending, 1'b0);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int r = 0; r < 7; r++) begin
            bus(1'b1, row_a[r], row_w[r]);
            rd_chk(row_a[r], row_e[r]);
        end
        avs_byteenable <= 4'h0;
        bus(1'b1, 8'h08, 8'h11);
        avs_byteenable <= 4'h1;
        rd_chk(8'h08, 8'ha5);
        $display("test regs done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 6; k++) rd_chk(8'(4 * k), 8'h00);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, 8'h00, 8'hff);
            bus(1'b1, 8'h04, 8'hff);
            {lvd_irq_enable, pwm_irq_enable} <= 2'b11;
            req_flags <= 16'h1 << i;
            offer(1'b1, 4'(i), 2'h0);
            if (en_map[i][5]) {lvd_irq_enable, pwm_irq_enable} <= 2'b00;
            else bus(1'b1, {5'h0, en_map[i][4], 2'h0}, 8'hff ^ (8'h1 << en_map[i][2:0]));
            offer(1'b0, 4'h0, 2'h0);
        end
        req_flags <= 16'hffff;
        bus(1'b1, 8'h04, 8'hff);
        bus(1'b1, 8'h00, 8'h7f);
        offer(1'b0, 4'h0, 2'h0);
        bus(1'b1, 8'h00, 8'hff);
        offer(1'b1, 4'h0, 2'h0);
        $display("test enables done");
        for (int i = 0; i < 16; i++) begin
            lvls(32'h3 << (2 * i));
            offer(1'b1, 4'(i), 2'h3);
        end
        lvls(32'h9000_0000);
        offer(1'b1, 4'hf, 2'h2);
        u_core.strobe(1, 0);
        chk(in_service, 4'h4);
        offer(1'b0, 4'h0, 2'h0);
        u_core.strobe(1, 0);
        chk(in_service, 4'h4);
        lvls(32'h9000_0003);
        offer(1'b1, 4'h0, 2'h3);
        lvls(32'h9000_0000);
        chk(irq_level, 2'h3);
        u_core.strobe(1, 3);
        chk(in_service, 4'hc);
        // Status word: in-service c, level 3, index 0, offer consumed
        bus(1'b0, 8'h18, 8'h00);
        chk(q, 32'h0000_0cc0);
        lvls(32'h9000_0003);
        offer(1'b0, 4'h0, 2'h0);
        u_core.strobe(2, 0);
        chk(in_service, 4'h4);
        lvls(32'h9000_0000);
        offer(1'b0, 4'h0, 2'h0);
        u_core.strobe(2, 2);
        chk(in_service, 4'h0);
        offer(1'b1, 4'hf, 2'h2);
        $display("test nesting done");
        close_out();
    end
endmodule // tb
